// ==== design/sfr_array_read.v ====
// serial flash main array read command path, sampled on ref_clk
//
// Contract
// - accept clock modes 0 and 3
// - legacy read: e8, address, four dummies
// - 264 pages: 11 page, 9 offset bits
// - 256 pages: 11 page, 8 offset bits
// - address counter advances by itself
// - dummies initialise, then data drives out
// - page end continues at next page
// - array end wraps to first page
// - select rise stops read, output released
// - reads leave data buffers untouched
// - fast read: 0b, address, one dummy
// - slow read: 03, address, no dummy
// - page read: d2, address, four dummies
// - page read wraps within same page
// - command starts at select fall, opcode
// - all fields most significant bit first
// - reset aborts read, stays idle
`timescale 1ns/1ps
`include "sfr_regs.vh"
module sfr_array_read (
    input  wire        ref_clk,
    input  wire        rst_b,
    input  wire        cs_b,
    input  wire        sck,
    input  wire        si,
    input  wire        page_256,
    input  wire [7:0]  mem_rd_data,
    output reg         so_out,
    output reg         so_oe,
    output reg         mem_rd,
    output reg  [10:0] mem_page,
    output reg  [8:0]  mem_offset
);

    // command states
    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_OPC    = 3'h1;
    localparam [2:0] ST_ADDR   = 3'h2;
    localparam [2:0] ST_DUMMY  = 3'h3;
    localparam [2:0] ST_DATA   = 3'h4;
    localparam [2:0] ST_IGNORE = 3'h5;

    wire [3:0] pins_sync;           // synchronised pin group
    wire       cs_b_s;              // select, active low
    wire       sck_s;               // serial clock
    wire       si_s;                // serial input
    wire       page_256_s;          // page size pin

    reg        sck_q;               // serial clock, one cycle older
    reg  [2:0] state;               // command state
    reg  [6:0] bit_cnt;             // header bits taken so far
    reg  [7:0] opcode;              // opcode shift register
    reg  [22:0] addr_sr;            // address shift register
    reg        page_mode;           // page size held for the command
    reg  [7:0] shreg;               // outgoing byte
    reg  [2:0] out_cnt;             // bit position in outgoing byte

    wire       sck_rise;            // serial clock rising edge
    wire       sck_fall;            // serial clock falling edge
    wire [7:0] next_opcode;         // opcode including current bit
    wire [23:0] next_addr;          // address including current bit
    wire [8:0] last_off;            // last byte offset of a page

    // header length per opcode, zero for unsupported commands
    function [6:0] hdr_bits;
        input [7:0] op;
        begin
            case (op)
                `SFR_OP_LEGACY_READ: hdr_bits = `SFR_HDR_BITS_LEGACY;
                `SFR_OP_FAST_READ:   hdr_bits = `SFR_HDR_BITS_FAST;
                `SFR_OP_SLOW_READ:   hdr_bits = `SFR_HDR_BITS_SLOW;
                `SFR_OP_PAGE_READ:   hdr_bits = `SFR_HDR_BITS_PAGE;
                default:             hdr_bits = `SFR_HDR_BITS_NONE;
            endcase
        end
    endfunction

    // page number from the 24 address bits
    function [10:0] dec_page;
        input [23:0] a;
        input        p256;
        begin
            if (p256) begin
                dec_page = a[`SFR_PAGE_MSB_256:`SFR_PAGE_LSB_256];
            end else begin
                dec_page = a[`SFR_PAGE_MSB_264:`SFR_PAGE_LSB_264];
            end
        end
    endfunction

    // byte offset from the 24 address bits
    function [8:0] dec_offset;
        input [23:0] a;
        input        p256;
        begin
            if (p256) begin
                dec_offset = {1'b0, a[`SFR_PAGE_LSB_256-1:0]};
            end else begin
                dec_offset = a[`SFR_PAGE_LSB_264-1:0];
            end
        end
    endfunction

    // pins cross into ref_clk through two flops
    sfr_sync #(
        .WIDTH     (4),
        .RESET_VAL (`SFR_SYNC_RESET)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .pin_in   ({page_256, si, sck, cs_b}),
        .sync_out (pins_sync)
    );

    assign cs_b_s     = pins_sync[0];
    assign sck_s      = pins_sync[1];
    assign si_s       = pins_sync[2];
    assign page_256_s = pins_sync[3];

    // edges of the synchronised serial clock
    assign sck_rise = sck_s & ~sck_q;
    assign sck_fall = ~sck_s & sck_q;

    // shift in msb first
    assign next_opcode = {opcode[6:0], si_s};
    assign next_addr   = {addr_sr, si_s};

    // page end depends on the page size held for this command
    assign last_off = page_mode ? `SFR_LAST_OFFSET_256 : `SFR_LAST_OFFSET_264;

    // command sequencer, serial shifter and address counter
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            // reset aborts everything and holds idle
            sck_q      <= 1'b0;
            state      <= ST_IDLE;
            bit_cnt    <= 7'h00;
            opcode     <= 8'h00;
            addr_sr    <= 23'h000000;
            page_mode  <= 1'b0;
            shreg      <= 8'h00;
            out_cnt    <= 3'h0;
            so_out     <= 1'b0;
            so_oe      <= 1'b0;
            mem_rd     <= 1'b0;
            mem_page   <= 11'h000;
            mem_offset <= 9'h000;
        end else begin
            sck_q  <= sck_s;
            mem_rd <= 1'b0;
            if (cs_b_s) begin
                // deselected: stop and release the output
                state  <= ST_IDLE;
                so_oe  <= 1'b0;
                so_out <= 1'b0;
            end else if (state == ST_IDLE) begin
                // select fall starts a new command, page size latched
                state     <= ST_OPC;
                bit_cnt   <= 7'h00;
                out_cnt   <= 3'h0;
                page_mode <= page_256_s;
                so_oe     <= 1'b0;
            end else if (sck_rise) begin
                // header bits taken on rising edges in mode 0 and 3
                case (state)
                    ST_OPC: begin
                        opcode  <= next_opcode;
                        bit_cnt <= bit_cnt + 7'h01;
                        if (bit_cnt == `SFR_OPC_LAST_BIT) begin
                            // unsupported opcodes wait for deselect
                            if (hdr_bits(next_opcode) != `SFR_HDR_BITS_NONE) begin
                                state <= ST_ADDR;
                            end else begin
                                state <= ST_IGNORE;
                            end
                        end
                    end
                    ST_ADDR: begin
                        addr_sr <= next_addr[22:0];
                        bit_cnt <= bit_cnt + 7'h01;
                        if (bit_cnt == `SFR_ADDR_LAST_BIT) begin
                            // start address decoded and first byte fetched
                            mem_page   <= dec_page(next_addr, page_mode);
                            mem_offset <= dec_offset(next_addr, page_mode);
                            mem_rd     <= 1'b1;
                            if (hdr_bits(opcode) == `SFR_HDR_BITS_SLOW) begin
                                state <= ST_DATA;
                            end else begin
                                state <= ST_DUMMY;
                            end
                        end
                    end
                    ST_DUMMY: begin
                        // dummy bits only count as initialisation time
                        bit_cnt <= bit_cnt + 7'h01;
                        if (bit_cnt == hdr_bits(opcode) - 7'h01) begin
                            state <= ST_DATA;
                        end
                    end
                    default: begin
                        // data and ignore phases take no input
                        state <= state;
                    end
                endcase
            end else if (sck_fall && state == ST_DATA) begin
                // data driven on falling edges, msb first
                so_oe   <= 1'b1;
                out_cnt <= out_cnt + 3'h1;
                if (out_cnt == 3'h0) begin
                    // new byte from the array, next one prefetched
                    shreg  <= {mem_rd_data[6:0], 1'b0};
                    so_out <= mem_rd_data[7];
                    mem_rd <= 1'b1;
                    if (mem_offset == last_off) begin
                        mem_offset <= 9'h000;
                        if (opcode == `SFR_OP_PAGE_READ) begin
                            mem_page <= mem_page;
                        end else if (mem_page == `SFR_LAST_PAGE) begin
                            mem_page <= 11'h000;
                        end else begin
                            mem_page <= mem_page + 11'h001;
                        end
                    end else begin
                        mem_offset <= mem_offset + 9'h001;
                    end
                end else begin
                    so_out <= shreg[7];
                    shreg  <= {shreg[6:0], 1'b0};
                end
            end
        end
    end

endmodule

// ==== design/sfr_regs.vh ====
// constants for the serial flash array read path
`ifndef SFR_REGS_VH
`define SFR_REGS_VH

// read opcodes
`define SFR_OP_LEGACY_READ   8'he8
`define SFR_OP_FAST_READ     8'h0b
`define SFR_OP_SLOW_READ     8'h03
`define SFR_OP_PAGE_READ     8'hd2

// header lengths in serial bits: opcode + address + dummy bytes
`define SFR_HDR_BITS_LEGACY  7'h40
`define SFR_HDR_BITS_FAST    7'h28
`define SFR_HDR_BITS_SLOW    7'h20
`define SFR_HDR_BITS_PAGE    7'h40
`define SFR_HDR_BITS_NONE    7'h00

// bit counter values closing the opcode and address fields
`define SFR_OPC_LAST_BIT     7'h07
`define SFR_ADDR_LAST_BIT    7'h1f

// address field layout inside the 24 address bits
`define SFR_PAGE_MSB_264     19
`define SFR_PAGE_LSB_264     9
`define SFR_PAGE_MSB_256     18
`define SFR_PAGE_LSB_256     8

// page and array ends
`define SFR_LAST_OFFSET_264  9'h107
`define SFR_LAST_OFFSET_256  9'h0ff
`define SFR_LAST_PAGE        11'h7ff

// serial clock limits placed on the host, in mhz
`define SFR_FAST_READ_CLOCK_LIMIT_MHZ  66
`define SFR_SLOW_READ_CLOCK_LIMIT_MHZ  33

// synchroniser reset value: {page_256, si, sck, cs_b}
`define SFR_SYNC_RESET       4'h1

`endif

// ==== design/sfr_sync.v ====
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sfr_sync #(
    parameter       WIDTH     = 4,
    parameter [3:0] RESET_VAL = 4'h0
) (
    input  wire             ref_clk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;    // first stage, read only by second stage

    // both stages reset to constants
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta     <= RESET_VAL[WIDTH-1:0];
            sync_out <= RESET_VAL[WIDTH-1:0];
        end else begin
            meta     <= pin_in;
            sync_out <= meta;
        end
    end

endmodule

// ==== tb/sfr_array_read_chk.sv ====
// port checker for the array read path
`timescale 1ns/1ps
module sfr_array_read_chk (
    input wire        ref_clk,
    input wire        rst_b,
    input wire        cs_b,
    input wire        page_256,
    input wire        so_oe,
    input wire        mem_rd,
    input wire [10:0] mem_page,
    input wire [8:0]  mem_offset
);
    reg [7:0]  low_cnt;   // select low time, saturating
    reg        in_frame;  // a fetch seen in this frame
    reg [10:0] last_page; // previous fetch page
    reg [8:0]  last_off;  // previous fetch offset
    // track select time and the previous fetch
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            low_cnt <= 8'h00;
            in_frame <= 1'b0;
            last_page <= 11'h000;
            last_off <= 9'h000;
        end else if (cs_b) begin
            low_cnt <= 8'h00;
            in_frame <= 1'b0;
        end else begin
            low_cnt <= (low_cnt == 8'hff) ? low_cnt : low_cnt + 8'h01;
            if (mem_rd) begin
                in_frame <= 1'b1;
                last_page <= mem_page;
                last_off <= mem_offset;
            end
        end
    end
    a_oe_off_deselect: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cs_b [*6] |-> !so_oe) else $error("output on while deselected");
    a_rd_one_cycle: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mem_rd |=> !mem_rd) else $error("fetch pulse too long");
    a_addr_step: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mem_rd && in_frame |-> (mem_offset == last_off + 9'h001 && mem_page == last_page)
        || (mem_offset == 9'h000 && (last_off == 9'h107 || last_off == 9'h0ff)))
        else $error("fetch address skipped");
    a_off_264_max: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mem_rd |-> mem_offset <= 9'h107) else $error("offset past page end");
    a_off_256_max: assert property (@(posedge ref_clk) disable iff (!rst_b)
        page_256 [*8] ##0 mem_rd |-> !mem_offset[8]) else $error("offset bit 8 in 256 mode");
    a_oe_after_hdr: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(so_oe) |-> low_cnt == 8'hff) else $error("output before header end");
    a_rd_in_frame: assert property (@(posedge ref_clk) disable iff (!rst_b)
        mem_rd |-> !$past(cs_b, 3) && low_cnt >= 8'he0)
        else $error("fetch outside command");
    a_reset_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(rst_b) |-> !so_oe && !mem_rd && mem_page == 11'h000 && mem_offset == 9'h000)
        else $error("not idle after reset");
endmodule
bind sfr_array_read sfr_array_read_chk u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .cs_b(cs_b), .page_256(page_256), .so_oe(so_oe), .mem_rd(mem_rd),
    .mem_page(mem_page), .mem_offset(mem_offset));

// ==== tb/sfr_mem_model.sv ====
// array memory model answering byte fetches
`timescale 1ns/1ps
module sfr_mem_model (
    input  wire        ref_clk,
    input  wire        mem_rd,
    input  wire [10:0] mem_page,
    input  wire [8:0]  mem_offset,
    output reg  [7:0]  mem_rd_data
);
    initial mem_rd_data = 8'h00;
    // sync read, holds until the next fetch
    always @(posedge ref_clk) begin
        if (mem_rd) begin
            mem_rd_data <= mem_page[7:0] ^ mem_offset[7:0] ^ {mem_offset[8], 7'h35}
                           ^ {mem_page[10:8], 5'h00};
        end
    end
endmodule

// ==== tb/test_serial_flash_array_read.sv ====
// self-checking bench for the array read path
`timescale 1ns/1ps
`include "sfr_regs.vh"
module test_serial_flash_array_read;
    reg         ref_clk = 1'b0;
    reg         rst_b = 1'b0;
    reg         cs_b = 1'b1;
    reg         sck = 1'b0;
    reg         si = 1'b0;
    reg         page_256 = 1'b0;
    wire [7:0]  mem_rd_data;
    wire        so_out;
    wire        so_oe;
    wire        mem_rd;
    wire [10:0] mem_page;
    wire [8:0]  mem_offset;
    wire        so_w = so_oe ? so_out : 1'bz; // released output reads z
    integer     bad_count = 0;
    integer     n_compared = 0;
    integer     i;
    integer     k;
    reg [31:0]  rnd;
    reg [7:0]   rx;
    reg [10:0]  pg;
    reg [8:0]   off;
    reg [7:0]   ops [0:3];
    reg [3:0]   nds [0:3];
    always #12.5 ref_clk = ~ref_clk;
    sfr_array_read u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b), .sck(sck),
        .si(si), .page_256(page_256), .mem_rd_data(mem_rd_data), .so_out(so_out),
        .so_oe(so_oe), .mem_rd(mem_rd), .mem_page(mem_page), .mem_offset(mem_offset));
    sfr_mem_model u_mem (.ref_clk(ref_clk), .mem_rd(mem_rd), .mem_page(mem_page),
        .mem_offset(mem_offset), .mem_rd_data(mem_rd_data));
    // compare and count
    task chk(input [63:0] what, input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("MISMATCH %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // one byte each way, msb first, eight ref_clk per sck period, sampled before the fall
    task xfer(input [7:0] tx, output [7:0] got);
        integer b;
        begin
            for (b = 7; b >= 0; b = b - 1) begin
                sck <= 1'b0;
                si <= tx[b];
                repeat (4) @(posedge ref_clk);
                sck <= 1'b1;
                repeat (4) @(posedge ref_clk);
                got[b] = so_w;
            end
        end
    endtask
    // expected byte held at {page, offset}
    function [7:0] exp_byte(input [19:0] a);
        exp_byte = a[16:9] ^ a[7:0] ^ {a[8], 7'h35} ^ {a[19:17], 5'h00};
    endfunction
    // next fetch address, page read stays in its page
    function [19:0] nxt(input [19:0] a, input p256, input pr);
        reg [8:0] last;
        begin
            last = p256 ? `SFR_LAST_OFFSET_256 : `SFR_LAST_OFFSET_264;
            if (a[8:0] != last) nxt = a + 20'h00001;
            else if (pr) nxt = {a[19:9], 9'h000};
            else nxt = {a[19:9] + 11'h001, 9'h000};
        end
    endfunction
    // whole command: header, three data bytes, deselect
    task cmd(input [7:0] o, input p256, input [10:0] p, input [8:0] f, input m3,
        input [3:0] nd, input good);
        integer j;
        reg [19:0] a;
        reg [23:0] ad;
        reg [7:0]  tx;
        begin
            a = {p, f};
            ad = p256 ? {5'h00, p, f[7:0]} : {4'h0, p, f};
            page_256 <= p256;
            sck <= m3;
            repeat (4) @(posedge ref_clk);
            cs_b <= 1'b0;
            for (j = 0; j < 7 + nd; j = j + 1) begin
                rnd = $urandom;
                tx = (j == 0) ? o : (j < 4) ? ad[31 - 8 * j -: 8] : rnd[7:0];
                xfer(tx, rx);
                if (j < 4 + nd) begin
                    chk("so_hdr", rx, 8'hzz);
                end else begin
                    chk("so_byte", rx, good ? exp_byte(a) : 8'hzz);
                    a = nxt(a, p256, o == `SFR_OP_PAGE_READ);
                end
            end
            @(posedge ref_clk) sck <= m3;
            repeat (4) @(posedge ref_clk);
            cs_b <= 1'b1;
            repeat (8) @(posedge ref_clk);
            chk("so_oe", {7'h00, so_oe}, 8'h00);
        end
    endtask
    // verdict and end of run
    task print_verdict;
        begin
            if (bad_count == 0 && n_compared > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask
    // watchdog, well past the expected run
    initial begin
        #1000000;
        bad_count = bad_count + 1;
        print_verdict;
    end
    // main sequence
    initial begin
        ops[0] = `SFR_OP_LEGACY_READ;
        ops[1] = `SFR_OP_FAST_READ;
        ops[2] = `SFR_OP_SLOW_READ;
        ops[3] = `SFR_OP_PAGE_READ;
        nds[0] = 4'h4;
        nds[1] = 4'h1;
        nds[2] = 4'h0;
        nds[3] = 4'h4;
        k = $urandom(36);
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge ref_clk);
        // reset in mid-read drops the output
        cs_b <= 1'b0;
        for (k = 0; k < 5; k = k + 1) xfer((k == 0) ? `SFR_OP_SLOW_READ : 8'h00, rx);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("so_oe", {7'h00, so_oe}, 8'h00);
        cs_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge ref_clk);
        // random starts, then page and array end crossings
        for (i = 0; i < 16; i = i + 1) begin
            rnd = $urandom;
            if (i >= 8) rnd[0] = i[2];
            pg = (i < 8) ? rnd[11:1] : `SFR_LAST_PAGE;
            off = rnd[0] ? {1'b0, rnd[19:12]} : rnd[20:12] % 9'h108;
            if (i >= 8) off = rnd[0] ? 9'h0fe : 9'h106;
            cmd(ops[i % 4], rnd[0], pg, off, rnd[21], nds[i % 4], 1'b1);
        end
        // unknown opcode gives no output
        cmd(8'h9f, 1'b0, 11'h000, 9'h000, 1'b0, 4'h1, 1'b0);
        print_verdict;
    end
endmodule
